// ---- core/lrmc_bus_timer.sv ----
module lrmc_bus_timer #(
  parameter int TIMEOUT_CYCLES = lrmc_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Watch
  input  wire logic enable,
  input  wire logic busy,
  input  wire logic activity,
  // Result
  output logic      timeout
);

  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT_CYCLES);

  logic [CW-1:0] idle_count;

  if (TIMEOUT_CYCLES < 1) begin : g_check
    $error("TIMEOUT_CYCLES must be at least one");
  end

  // Fires one cycle after the quiet time reaches the limit
  always_ff @(posedge clk) begin
    if (srst) begin
      idle_count <= '0;
      timeout    <= 1'b0;
    end else if (!enable || !busy || activity || timeout) begin
      idle_count <= '0;
      timeout    <= 1'b0;
    end else if (idle_count == LIMIT) begin
      idle_count <= '0;
      timeout    <= 1'b1; // (R6)
    end else begin
      idle_count <= idle_count + CW'(1);
      timeout    <= 1'b0;
    end
  end

endmodule // lrmc_bus_timer

// ---- core/lrmc_pkg.sv ----
package lrmc_pkg;

  // Command codes of the two registers
  localparam logic [7:0] CMD_LOCK_RESET = 8'hd0;
  localparam logic [7:0] CMD_MFR_CONFIG = 8'hd1;

  // Power-on values
  localparam logic [7:0] LOCK_RESET_POR = 8'h00;
  localparam logic [7:0] MFR_CONFIG_POR = 8'h07;

  // Field positions of the lock and soft reset register
  localparam int LOCK_BIT       = 0;
  localparam int SOFT_RESET_BIT = 1;

  // Field positions of the manufacturer configuration register
  localparam int SAVE_PHASE_LSB  = 6;
  localparam int BUS_TIMEOUT_BIT = 3;
  localparam int FAULT_EN_BIT    = 2;
  localparam int ALERT_EN_BIT    = 1;
  localparam int MONITOR_EN_BIT  = 0;

  // Power save phase count code that selects two phases
  localparam logic [1:0] SAVE_TWO_PHASES = 2'h1;

  // Bus timeout
  localparam int CLK_HZ             = 25_000_000;
  localparam int TIMEOUT_MS         = 35;
  localparam int TIMEOUT_CYCLES     = (CLK_HZ / 1000) * TIMEOUT_MS;

  // Serial port
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;
  localparam logic [1:0] PIN_IDLE         = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h2,
    ST_CMD       = 4'h3,
    ST_CMD_ACK   = 4'h4,
    ST_WDATA     = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA     = 4'h7,
    ST_RDATA_ACK = 4'h8,
    ST_IGNORE    = 4'h9
  } lrmc_state_type;

endpackage

// ---- core/lrmc_reg_bank.sv ----
module lrmc_reg_bank (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Register access
  lrmc_reg_if.bank  reg_bus,
  // Settings
  output logic       locked,
  output logic [1:0] power_save_phase_count,
  output logic       bus_timeout_enable,
  output logic       fault_enable,
  output logic       alert_enable,
  output logic       monitor_enable
);

  logic [7:0] mfr_config;
  logic       lock_write;
  logic       cfg_write;

  // Lock bit only falls at power-on reset; soft reset cannot reach it
  assign lock_write = reg_bus.wr_stb && reg_bus.cmd == lrmc_pkg::CMD_LOCK_RESET;
  assign cfg_write  = reg_bus.wr_stb && reg_bus.cmd == lrmc_pkg::CMD_MFR_CONFIG;

  always_ff @(posedge clk) begin
    if (srst) begin
      locked <= lrmc_pkg::LOCK_RESET_POR[lrmc_pkg::LOCK_BIT];
    end else if (lock_write && !locked) begin // (R4)
      if (reg_bus.wdata[lrmc_pkg::LOCK_BIT]) begin
        locked <= 1'b1; // (R3)
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mfr_config <= lrmc_pkg::MFR_CONFIG_POR;
    end else if (!locked) begin // (R2) (R4)
      if (lock_write && reg_bus.wdata[lrmc_pkg::SOFT_RESET_BIT]) begin
        mfr_config <= lrmc_pkg::MFR_CONFIG_POR; // (R1)
      end else if (cfg_write) begin
        mfr_config <= reg_bus.wdata & 8'hcf; // (R10)
      end
    end
  end

  function automatic logic [7:0] read_value(input logic [7:0] cmd);
    case (cmd)
      lrmc_pkg::CMD_LOCK_RESET: read_value = {7'h00, locked};
      lrmc_pkg::CMD_MFR_CONFIG: read_value = mfr_config;
      default:                  read_value = 8'h00;
    endcase
  endfunction

  assign reg_bus.rdata = read_value(reg_bus.cmd);

  assign power_save_phase_count =
    mfr_config[lrmc_pkg::SAVE_PHASE_LSB +: 2];
  assign bus_timeout_enable = mfr_config[lrmc_pkg::BUS_TIMEOUT_BIT];
  assign fault_enable       = mfr_config[lrmc_pkg::FAULT_EN_BIT];
  assign alert_enable       = mfr_config[lrmc_pkg::ALERT_EN_BIT];
  assign monitor_enable     = mfr_config[lrmc_pkg::MONITOR_EN_BIT];

endmodule // lrmc_reg_bank

// ---- core/lrmc_reg_if.sv ----
interface lrmc_reg_if;
  logic       wr_stb;
  logic [7:0] cmd;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport engine (
    output wr_stb,
    output cmd,
    output wdata,
    input  rdata
  );

  modport bank (
    input  wr_stb,
    input  cmd,
    input  wdata,
    output rdata
  );
endinterface

// ---- core/lrmc_top.sv ----
// Contract
// (R1) Soft reset bit restores power-on register values
// (R2) Soft reset ignored while write lock set
// (R3) Writing lock bit freezes all limit values
// (R4) Locked registers read-only until power cycles
// (R5) Phase count 01 gives two phases, else one
// (R6) Enabled bus timeout releases bus after 35 ms
// (R7) Fault enable gates fault pin, defaults one
// (R8) Alert pin driven only while alert enabled
// (R9) Monitor enable starts conversions and voltage monitoring
// (R10) Reserved config bits read zero, ignore writes
module lrmc_top #(
  parameter logic [6:0] DEV_ADDR       = lrmc_pkg::DEV_ADDR_DEFAULT,
  parameter int         TIMEOUT_CYCLES = lrmc_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Serial host port
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // Events from the controller core
  input  wire logic fault_event,
  input  wire logic alert_event,
  // Controls and pins
  output logic      fault_pin,
  output logic      alert_pin,
  output logic      alert_drive,
  output logic      save_two_phase,
  output logic      monitor_run,
  output logic      write_locked
);

  lrmc_reg_if reg_bus ();

  logic [1:0]               pin_meta;
  logic [1:0]               pin_sync;
  logic                     scl_prev;
  logic                     sda_prev;
  logic                     scl_now;
  logic                     sda_now;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     start_seen;
  logic                     stop_seen;
  logic                     activity;
  logic                     busy;
  logic                     timeout;
  lrmc_pkg::lrmc_state_type state;
  logic [7:0]               shreg;
  logic [2:0]               bit_count;
  logic                     byte_done;
  logic                     read_mode;
  logic                     read_acked;
  logic                     drive_low;
  logic                     locked;
  logic [1:0]               power_save_phase_count;
  logic                     bus_timeout_enable;
  logic                     fault_enable;
  logic                     alert_enable;
  logic                     monitor_enable;

  if (TIMEOUT_CYCLES < 1) begin : g_check
    $error("TIMEOUT_CYCLES must be at least one");
  end

  // Two stages on both pins; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_meta <= lrmc_pkg::PIN_IDLE;
      pin_sync <= lrmc_pkg::PIN_IDLE;
    end else begin
      pin_meta <= {sda_in, scl_in};
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_now;
      sda_prev <= sda_now;
    end
  end

  assign scl_now    = pin_sync[0];
  assign sda_now    = pin_sync[1];
  assign scl_rise   = scl_now && !scl_prev;
  assign scl_fall   = !scl_now && scl_prev;
  assign start_seen = scl_now && scl_prev && sda_prev && !sda_now;
  assign stop_seen  = scl_now && scl_prev && !sda_prev && sda_now;
  assign activity   = (scl_now != scl_prev) || (sda_now != sda_prev);
  assign busy       = state != lrmc_pkg::ST_IDLE;

  lrmc_bus_timer #(
    .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
  ) u_timer (
    .clk      (clk),
    .srst     (srst),
    .enable   (bus_timeout_enable),
    .busy     (busy),
    .activity (activity),
    .timeout  (timeout)
  );

  lrmc_reg_bank u_bank (
    .clk                    (clk),
    .srst                   (srst),
    .reg_bus                (reg_bus.bank),
    .locked                 (locked),
    .power_save_phase_count (power_save_phase_count),
    .bus_timeout_enable     (bus_timeout_enable),
    .fault_enable           (fault_enable),
    .alert_enable           (alert_enable),
    .monitor_enable         (monitor_enable)
  );

  // Byte engine: data is sampled on the clock rise, driven after the fall
  always_ff @(posedge clk) begin
    if (srst) begin
      state         <= lrmc_pkg::ST_IDLE;
      shreg         <= 8'h00;
      bit_count     <= 3'h0;
      byte_done     <= 1'b0;
      read_mode     <= 1'b0;
      read_acked    <= 1'b0;
      drive_low     <= 1'b0;
      reg_bus.cmd   <= 8'h00;
      reg_bus.wdata <= 8'h00;
    end else if (timeout || stop_seen) begin
      // A stuck host cannot hold the data line through us forever
      state     <= lrmc_pkg::ST_IDLE; // (R6)
      drive_low <= 1'b0; // (R6)
      byte_done <= 1'b0;
    end else if (start_seen) begin
      state     <= lrmc_pkg::ST_ADDR;
      bit_count <= 3'h0;
      byte_done <= 1'b0;
      drive_low <= 1'b0;
    end else if (scl_rise) begin
      case (state)
        lrmc_pkg::ST_ADDR, lrmc_pkg::ST_CMD, lrmc_pkg::ST_WDATA: begin
          shreg     <= {shreg[6:0], sda_now};
          bit_count <= bit_count + 3'h1;
          byte_done <= bit_count == 3'h7;
        end
        lrmc_pkg::ST_RDATA: begin
          bit_count <= bit_count + 3'h1;
          byte_done <= bit_count == 3'h7;
        end
        lrmc_pkg::ST_RDATA_ACK: begin
          read_acked <= !sda_now;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        lrmc_pkg::ST_ADDR: begin
          if (byte_done) begin
            byte_done <= 1'b0;
            if (shreg[7:1] == DEV_ADDR) begin
              read_mode <= shreg[0];
              drive_low <= 1'b1;
              state     <= lrmc_pkg::ST_ADDR_ACK;
            end else begin
              state <= lrmc_pkg::ST_IDLE;
            end
          end
        end
        lrmc_pkg::ST_CMD: begin
          if (byte_done) begin
            byte_done   <= 1'b0;
            reg_bus.cmd <= shreg;
            drive_low   <= 1'b1;
            state       <= lrmc_pkg::ST_CMD_ACK;
          end
        end
        lrmc_pkg::ST_WDATA: begin
          if (byte_done) begin
            byte_done     <= 1'b0;
            reg_bus.wdata <= shreg;
            drive_low     <= 1'b1;
            state         <= lrmc_pkg::ST_WDATA_ACK;
          end
        end
        lrmc_pkg::ST_ADDR_ACK: begin
          if (read_mode) begin
            shreg     <= reg_bus.rdata;
            drive_low <= !reg_bus.rdata[7];
            state     <= lrmc_pkg::ST_RDATA;
          end else begin
            drive_low <= 1'b0;
            state     <= lrmc_pkg::ST_CMD;
          end
        end
        lrmc_pkg::ST_CMD_ACK: begin
          drive_low <= 1'b0;
          state     <= lrmc_pkg::ST_WDATA;
        end
        lrmc_pkg::ST_WDATA_ACK: begin
          // Registers are one byte wide; extra bytes are refused
          drive_low <= 1'b0;
          state     <= lrmc_pkg::ST_IGNORE;
        end
        lrmc_pkg::ST_RDATA: begin
          if (byte_done) begin
            byte_done <= 1'b0;
            drive_low <= 1'b0;
            state     <= lrmc_pkg::ST_RDATA_ACK;
          end else begin
            shreg     <= {shreg[6:0], 1'b0};
            drive_low <= !shreg[6];
          end
        end
        lrmc_pkg::ST_RDATA_ACK: begin
          if (read_acked) begin
            shreg     <= reg_bus.rdata;
            drive_low <= !reg_bus.rdata[7];
            state     <= lrmc_pkg::ST_RDATA;
          end else begin
            state <= lrmc_pkg::ST_IGNORE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Write strobe one cycle, when the data byte has been taken
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_bus.wr_stb <= 1'b0;
    end else begin
      reg_bus.wr_stb <= scl_fall && byte_done && !timeout && !stop_seen
                        && !start_seen && state == lrmc_pkg::ST_WDATA;
    end
  end

  // Open-drain data line: only ever pulled low
  always_ff @(posedge clk) begin
    if (srst) begin
      sda_out <= 1'b0;
      sda_oe  <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oe  <= drive_low && !timeout && !stop_seen; // (R6)
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fault_pin <= 1'b0;
    end else begin
      fault_pin <= fault_event && fault_enable; // (R7)
    end
  end

  // Alert pin floats when disabled, rather than showing a stale level
  always_ff @(posedge clk) begin
    if (srst) begin
      alert_pin   <= 1'b0;
      alert_drive <= 1'b0;
    end else begin
      alert_pin   <= alert_event && alert_enable; // (R8)
      alert_drive <= alert_enable; // (R8)
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      save_two_phase <= 1'b0;
      monitor_run    <= 1'b0;
      write_locked   <= 1'b0;
    end else begin
      save_two_phase <=
        power_save_phase_count == lrmc_pkg::SAVE_TWO_PHASES; // (R5)
      monitor_run    <= monitor_enable; // (R9)
      write_locked   <= locked; // (R4)
    end
  end

endmodule // lrmc_top

// ---- verif/lrmc_host_model.sv ----
module lrmc_host_model (
  // Clock
  input  wire logic clk,
  // Serial wire
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b1;
  int   half = 10;
  initial scl = 1'b1;
  // Open drain with pull-up: either party pulls low
  assign sda = drv & ~sda_oe;

  task automatic hw();
    repeat (half) @(negedge clk);
  endtask
  // Data moves two cycles after the clock fall, so no false start/stop
  task automatic pulse(output logic s);
    hw();
    scl = 1'b1;
    hw();
    s = sda;
    scl = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic start();
    drv = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    drv = 1'b0;
    hw();
    scl = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic stop();
    drv = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    drv = 1'b1;
    hw();
  endtask
  task automatic bits(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      drv = b[i];
      pulse(s);
    end
  endtask
  task automatic ack_slot(output logic a);
    logic s;
    drv = 1'b1;
    pulse(s);
    a = ~s;
  endtask
  task automatic tx(input logic [7:0] b, output logic a);
    bits(b);
    ack_slot(a);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d,
                    output logic [2:0] a);
    start();
    tx({lrmc_pkg::DEV_ADDR_DEFAULT, 1'b0}, a[2]);
    tx(c, a[1]);
    tx(d, a[0]);
    stop();
  endtask
  // Reads one byte and answers with a not-acknowledge
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    logic k;
    start();
    tx({lrmc_pkg::DEV_ADDR_DEFAULT, 1'b0}, k);
    tx(c, k);
    start();
    tx({lrmc_pkg::DEV_ADDR_DEFAULT, 1'b1}, k);
    drv = 1'b1;
    for (int i = 7; i >= 0; i--) pulse(d[i]);
    pulse(k);
    stop();
  endtask
endmodule // lrmc_host_model

// ---- verif/lrmc_monitor.sv ----
module lrmc_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Events and controls
  input wire logic fault_event,
  input wire logic alert_event,
  input wire logic fault_pin,
  input wire logic alert_pin,
  input wire logic alert_drive,
  input wire logic save_two_phase,
  input wire logic monitor_run,
  input wire logic write_locked
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence por_hold;
    !write_locked && !sda_oe && !alert_drive;
  endsequence
  sequence por_vals;
    alert_drive && monitor_run && !save_two_phase && !write_locked;
  endsequence

  AST_POR: assert property ($fell(srst) |-> por_hold ##1 por_vals)
    else $error("power-on outputs wrong");
  AST_FAULT_GATE: assert property (fault_pin |-> $past(fault_event))
    else $error("fault pin without event");
  AST_ALERT_GATE: assert property (alert_pin |->
    alert_drive && $past(alert_event))
    else $error("alert pin without enable");
  AST_LOCK_STICKY: assert property (write_locked |=> write_locked)
    else $error("lock cleared");
  AST_LOCK_AT_ACK: assert property ($rose(write_locked) |-> sda_oe)
    else $error("lock set outside a write");
  AST_PHASE_AT_ACK: assert property ($changed(save_two_phase) &&
    !$past(srst, 2) |-> sda_oe)
    else $error("phase select moved outside a write");
  AST_MON_AT_ACK: assert property ($changed(monitor_run) &&
    !$past(srst, 2) |-> sda_oe)
    else $error("monitor moved outside a write");
  AST_FREEZE: assert property (write_locked |=>
    $stable(save_two_phase) && $stable(monitor_run) && $stable(alert_drive))
    else $error("setting changed while locked");
  AST_OE_SCL_LOW: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data driven while clock high");
endmodule // lrmc_monitor

bind lrmc_top lrmc_monitor mon_u (
  .clk(clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .fault_event(fault_event),
  .alert_event(alert_event), .fault_pin(fault_pin),
  .alert_pin(alert_pin), .alert_drive(alert_drive),
  .save_two_phase(save_two_phase), .monitor_run(monitor_run),
  .write_locked(write_locked)
);

// ---- verif/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO = 50;
  logic clk         = 1'b0;
  logic srst        = 1'b1;
  logic fault_event = 1'b0;
  logic alert_event = 1'b0;
  logic scl;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic fault_pin;
  logic alert_pin;
  logic alert_drive;
  logic save_two_phase;
  logic monitor_run;
  logic write_locked;
  int   num_errors = 0;
  int   cmp_count  = 0;

  always #20 clk = ~clk;

  lrmc_top #(.TIMEOUT_CYCLES(TO)) dut_u (
    .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .fault_event(fault_event),
    .alert_event(alert_event), .fault_pin(fault_pin),
    .alert_pin(alert_pin), .alert_drive(alert_drive),
    .save_two_phase(save_two_phase), .monitor_run(monitor_run),
    .write_locked(write_locked)
  );
  lrmc_host_model host_u (
    .clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda)
  );

  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset();
    @(negedge clk);
    srst = 1'b1;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic wrr(input logic [7:0] c, input logic [7:0] d);
    logic [2:0] a;
    host_u.wr(c, d, a);
    chk({5'h0, a}, 8'h07);
    repeat (2) @(negedge clk);
  endtask
  task automatic rdc(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(c, d);
    chk(d, e);
  endtask
  task automatic ctl(input logic [7:0] e);
    chk({3'h0, save_two_phase, monitor_run, alert_drive, fault_pin,
         alert_pin}, e);
  endtask
  // Each table entry sets all reserved bits, which must read back as 0
  task automatic t_config();
    logic [7:0] tab [4] = '{8'h30, 8'h75, 8'hb2, 8'hfc};
    foreach (tab[i]) begin
      wrr(lrmc_pkg::CMD_MFR_CONFIG, tab[i]);
      ctl({3'h0, tab[i][7:6] == 2'h1, tab[i][0], tab[i][1], tab[i][2],
           tab[i][1]});
      rdc(lrmc_pkg::CMD_MFR_CONFIG, tab[i] & 8'hcf);
    end
  endtask
  task automatic t_soft_reset();
    wrr(lrmc_pkg::CMD_LOCK_RESET, 8'h02);
    rdc(lrmc_pkg::CMD_MFR_CONFIG, 8'h07);
    rdc(lrmc_pkg::CMD_LOCK_RESET, 8'h00);
    ctl(8'h0f);
  endtask
  // Host freezes with the address acknowledge on the wire
  task automatic stall(input logic held);
    logic a;
    host_u.start();
    host_u.bits({lrmc_pkg::DEV_ADDR_DEFAULT, 1'b0});
    repeat (4 * TO) @(negedge clk);
    chk({7'h0, sda_oe}, {7'h0, held});
    host_u.ack_slot(a);
    host_u.stop();
  endtask
  task automatic t_timeout();
    stall(1'b1);
    host_u.half = 40;
    wrr(lrmc_pkg::CMD_MFR_CONFIG, 8'h0f);
    host_u.half = 10;
    stall(1'b0);
    rdc(lrmc_pkg::CMD_MFR_CONFIG, 8'h0f);
  endtask
  task automatic t_lock();
    wrr(lrmc_pkg::CMD_LOCK_RESET, 8'h01);
    chk({7'h0, write_locked}, 8'h01);
    wrr(lrmc_pkg::CMD_MFR_CONFIG, 8'h40);
    rdc(lrmc_pkg::CMD_MFR_CONFIG, 8'h0f);
    wrr(lrmc_pkg::CMD_LOCK_RESET, 8'h02);
    rdc(lrmc_pkg::CMD_MFR_CONFIG, 8'h0f);
    wrr(lrmc_pkg::CMD_LOCK_RESET, 8'h00);
    rdc(lrmc_pkg::CMD_LOCK_RESET, 8'h01);
    do_reset();
    rdc(lrmc_pkg::CMD_LOCK_RESET, 8'h00);
  endtask

  // Generous bound: the whole sequence needs about 20k cycles
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  initial begin
    do_reset();
    fault_event = 1'b1;
    alert_event = 1'b1;
    rdc(lrmc_pkg::CMD_LOCK_RESET, 8'h00);
    rdc(lrmc_pkg::CMD_MFR_CONFIG, 8'h07);
    ctl(8'h0f);
    t_config();
    t_soft_reset();
    t_timeout();
    t_lock();
    stop_test();
  end
endmodule // tb_top
